// *** i2c_master_controller.v ***
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_defines.vh"
module i2c_master_controller (
  input wire clk,
  input wire reset_n,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output wire [31:0] regRdata,
  output wire irq,
  input wire sclIn,
  output wire sclOut,
  output wire sclOeN,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOeN
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_START = 3'd1;
  localparam S_LOW = 3'd2;
  localparam S_HIGH = 3'd3;
  localparam S_STOP1 = 3'd4;
  localparam S_STOP2 = 3'd5;
  localparam S_STOP3 = 3'd6;

  reg [2:0] state_r;
  reg [3:0] bitCnt_r;
  reg [7:0] shift_r;
  reg addrPhase_r;
  reg readDir_r;
  reg lastAck_r;
  reg nackPend_r;
  reg stopReq_r;
  reg lockout_r;
  reg enable_r;
  reg sclLow_r;
  reg sdaLow_r;
  reg transfer_complete_flag_r;
  reg receive_ready_flag_r;
  reg transmit_ready_flag_r;
  reg ovre_r;
  reg nack_r;
  reg [7:0] rhr_r;
  reg [7:0] thr_r;
  reg [6:0] devAddr_r;
  reg readMode_r;
  reg [7:0] lowDiv_r;
  reg [7:0] highDiv_r;
  reg [2:0] prescale_r;
  reg [3:0] intStat_r;
  reg [3:0] intMask_r;
  reg [3:0] flagPrev_r;
  reg [31:0] rdata_r;
  reg [31:0] rdata_nxt;

  wire sclSync;
  wire sdaSync;
  wire tmrDone;
  wire wrCtl;
  wire rdStat;
  wire startGo;
  wire swReset;
  wire highPhase;
  wire advance;
  wire transmitting;
  wire [3:0] flagNow;
  wire [3:0] flagRise;
  wire [31:0] statusWord;

  // ----------------------------------------
  // Pin sampling and phase timing
  // ----------------------------------------
  bit_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .din({sclIn, sdaIn}),
    .dout({sclSync, sdaSync})
  );

  assign highPhase = (state_r == S_START) || (state_r == S_HIGH) || (state_r == S_STOP3);
  // Held or frozen phases do not advance
  assign advance = enable_r && tmrDone && (state_r != S_IDLE);

  phase_timer u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .lowDiv(lowDiv_r),
    .highDiv(highDiv_r),
    .prescaleExp(prescale_r),
    .selHigh(highPhase),
    .restart(advance || startGo),
    // High phase counts only once a stretching slave lets the clock rise
    .run(enable_r && (!highPhase || sclSync)),
    .done(tmrDone)
  );

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign wrCtl = regWrite && (regAddr == `OFS_CONTROL);
  assign rdStat = regRead && (regAddr == `OFS_STATUS);
  assign swReset = wrCtl && regWdata[`CTL_SWRESET];
  assign startGo = wrCtl && regWdata[`CTL_START] && !regWdata[`CTL_DISABLE] && !swReset
                   && (enable_r || regWdata[`CTL_ENABLE]) && !lockout_r
                   && (state_r == S_IDLE);
  assign transmitting = addrPhase_r || !readDir_r;

  // ----------------------------------------
  // Transfer engine and status flags
  // ----------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= S_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      addrPhase_r <= 1'b0;
      readDir_r <= 1'b0;
      lastAck_r <= 1'b0;
      nackPend_r <= 1'b0;
      stopReq_r <= 1'b0;
      lockout_r <= 1'b0;
      enable_r <= 1'b0;
      sclLow_r <= 1'b0;
      sdaLow_r <= 1'b0;
      transfer_complete_flag_r <= `RST_TRANSFER_COMPLETE_FLAG;
      receive_ready_flag_r <= 1'b0;
      transmit_ready_flag_r <= `RST_TRANSMIT_READY_FLAG;
      ovre_r <= 1'b0;
      nack_r <= 1'b0;
      rhr_r <= 8'h00;
      thr_r <= 8'h00;
    end else if (swReset) begin
      // Reset leaves the engine idle but cannot undo a dead engine
      if ((state_r != S_IDLE) && sclLow_r) begin
        lockout_r <= 1'b1;
      end
      state_r <= S_IDLE;
      bitCnt_r <= 4'h0;
      addrPhase_r <= 1'b0;
      nackPend_r <= 1'b0;
      stopReq_r <= 1'b0;
      enable_r <= 1'b0;
      sclLow_r <= 1'b0;
      sdaLow_r <= 1'b0;
      transfer_complete_flag_r <= `RST_TRANSFER_COMPLETE_FLAG;
      receive_ready_flag_r <= 1'b0;
      transmit_ready_flag_r <= `RST_TRANSMIT_READY_FLAG;
      ovre_r <= 1'b0;
      nack_r <= 1'b0;
    end else begin
      // Software clears first; hardware sets below win
      if (wrCtl) begin
        if (regWdata[`CTL_DISABLE]) begin
          enable_r <= 1'b0;
        end else if (regWdata[`CTL_ENABLE]) begin
          enable_r <= 1'b1;
        end
        if (regWdata[`CTL_STOP] && (state_r != S_IDLE)) begin
          stopReq_r <= 1'b1;
        end
      end
      if (rdStat) begin
        nack_r <= 1'b0;
        nackPend_r <= 1'b0;
      end
      if (regRead && (regAddr == `OFS_RXHOLD)) begin
        receive_ready_flag_r <= 1'b0;
      end
      if (regWrite && (regAddr == `OFS_TXHOLD)) begin
        thr_r <= regWdata[7:0];
        transmit_ready_flag_r <= 1'b0;
      end
      if (startGo) begin
        state_r <= S_START;
        sdaLow_r <= 1'b1;
        transfer_complete_flag_r <= 1'b0;
        shift_r <= {devAddr_r, readMode_r};
        addrPhase_r <= 1'b1;
        readDir_r <= readMode_r;
        bitCnt_r <= 4'h0;
        stopReq_r <= 1'b0;
        nackPend_r <= 1'b0;
      end
      // Data moves one cycle into the low phase, clear of both clock edges
      if (enable_r && (state_r == S_LOW) && !tmrDone) begin
        if (bitCnt_r[3]) begin
          // Ack slot: a reader acks unless a stop is pending
          sdaLow_r <= !transmitting && !stopReq_r;
          lastAck_r <= stopReq_r;
        end else begin
          sdaLow_r <= transmitting && !shift_r[7];
        end
      end
      if (advance) begin
        case (state_r)
          S_START: begin
            state_r <= S_LOW;
            sclLow_r <= 1'b1;
          end
          S_LOW: begin
            state_r <= S_HIGH;
            sclLow_r <= 1'b0;
          end
          S_HIGH: begin
            sclLow_r <= 1'b1;
            if (!bitCnt_r[3]) begin
              shift_r <= {shift_r[6:0], sdaSync};
              bitCnt_r <= bitCnt_r + 4'h1;
              state_r <= S_LOW;
              if ((bitCnt_r == 4'h7) && !addrPhase_r) begin
                // Loaded for both directions; only reads raise flags
                rhr_r <= {shift_r[6:0], sdaSync};
                if (readDir_r) begin
                  receive_ready_flag_r <= 1'b1;
                  ovre_r <= ovre_r || receive_ready_flag_r;
                end
              end
            end else begin
              bitCnt_r <= 4'h0;
              addrPhase_r <= 1'b0;
              sdaLow_r <= 1'b0;
              if (transmitting && sdaSync) begin
                nackPend_r <= 1'b1;
                state_r <= S_STOP1;
              end else if (readDir_r) begin
                state_r <= (!addrPhase_r && lastAck_r) ? S_STOP1 : S_LOW;
              end else if (!transmit_ready_flag_r && !stopReq_r) begin
                shift_r <= thr_r;
                transmit_ready_flag_r <= 1'b1;
                state_r <= S_LOW;
              end else begin
                state_r <= S_STOP1;
              end
            end
          end
          S_STOP1: begin
            sdaLow_r <= 1'b1;
            state_r <= S_STOP2;
          end
          S_STOP2: begin
            sclLow_r <= 1'b0;
            state_r <= S_STOP3;
          end
          S_STOP3: begin
            sdaLow_r <= 1'b0;
            state_r <= S_IDLE;
            transfer_complete_flag_r <= 1'b1;
            nack_r <= nackPend_r || (nack_r && !rdStat);
            nackPend_r <= 1'b0;
          end
          default: begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      devAddr_r <= 7'h00;
      readMode_r <= 1'b0;
      lowDiv_r <= `RST_DIV;
      highDiv_r <= `RST_DIV;
      prescale_r <= `RST_EXP;
    end else if (regWrite) begin
      if (regAddr == `OFS_MODE) begin
        devAddr_r <= regWdata[`MODE_ADDR_LSB +: 7];
        readMode_r <= regWdata[`MODE_READ];
      end
      if (regAddr == `OFS_CLKWAVE) begin
        lowDiv_r <= regWdata[`WAVE_LOW_LSB +: 8];
        highDiv_r <= regWdata[`WAVE_HIGH_LSB +: 8];
        prescale_r <= regWdata[`WAVE_EXP_LSB +: 3];
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // Index order: transfer_complete_flag, receive_ready_flag, transmit_ready_flag, nack
  assign flagNow = {nack_r, transmit_ready_flag_r, receive_ready_flag_r, transfer_complete_flag_r};
  assign flagRise = flagNow & ~flagPrev_r;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flagPrev_r <= 4'hf;
      intStat_r <= 4'h0;
      intMask_r <= 4'h0;
    end else begin
      flagPrev_r <= flagNow;
      if (regWrite && (regAddr == `OFS_INTMASK)) begin
        intMask_r <= {regWdata[`ST_NACK], regWdata[`ST_TRANSMIT_READY_FLAG],
                      regWdata[`ST_RECEIVE_READY_FLAG], regWdata[`ST_TRANSFER_COMPLETE_FLAG]};
      end
      if (regWrite && (regAddr == `OFS_INTSTAT)) begin
        intStat_r <= (intStat_r & ~{regWdata[`ST_NACK], regWdata[`ST_TRANSMIT_READY_FLAG],
                      regWdata[`ST_RECEIVE_READY_FLAG], regWdata[`ST_TRANSFER_COMPLETE_FLAG]}) | flagRise;
      end else begin
        intStat_r <= intStat_r | flagRise;
      end
    end
  end

  assign irq = |(intStat_r & intMask_r);

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  function [31:0] spread;
    input [3:0] f;
    begin
      spread = 32'h00000000;
      spread[`ST_TRANSFER_COMPLETE_FLAG] = f[0];
      spread[`ST_RECEIVE_READY_FLAG] = f[1];
      spread[`ST_TRANSMIT_READY_FLAG] = f[2];
      spread[`ST_NACK] = f[3];
    end
  endfunction

  assign statusWord = spread(flagNow)
                      | ({31'h00000000, ovre_r} << `ST_OVRE)
                      | ({31'h00000000, enable_r} << `ST_ENABLED)
                      | ({31'h00000000, lockout_r} << `ST_LOCKOUT);

  always @* begin
    rdata_nxt = 32'h00000000;
    case (regAddr)
      `OFS_MODE: rdata_nxt = {23'h000000, readMode_r, 1'b0, devAddr_r};
      `OFS_CLKWAVE: rdata_nxt = {13'h0000, prescale_r, highDiv_r, lowDiv_r};
      `OFS_STATUS: rdata_nxt = statusWord;
      `OFS_INTSTAT: rdata_nxt = spread(intStat_r);
      `OFS_INTMASK: rdata_nxt = spread(intMask_r);
      `OFS_RXHOLD: rdata_nxt = {24'h000000, rhr_r};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 32'h00000000;
    end else if (regRead) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  assign regRdata = rdata_r;

  // Open drain: only ever pull low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOeN = ~sclLow_r;
  assign sdaOeN = ~sdaLow_r;
endmodule
`default_nettype wire

// *** i2c_defines.vh ***
// Behaviour
// - Software reset mid-frame with clock low locks out all later transfers.
// - Writing the disable command freezes a running transfer at once.
// - Disabling leaves transfer-complete and transmit-ready flags untouched.
// - Status read between missing ack and completion suppresses the not-ack flag.
// - Transfer-complete and not-ack rise in the same cycle.
// - Reading the status register clears the not-ack flag.
// - Receive holding register loads at every data byte, whatever the direction.
// - A held received byte is overwritten by the next transmit byte.
// - That overwrite raises neither receive-ready nor overrun.
`ifndef I2C_DEFINES_VH
`define I2C_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_MODE 8'h04
`define OFS_CLKWAVE 8'h10
`define OFS_STATUS 8'h20
`define OFS_INTSTAT 8'h24
`define OFS_INTMASK 8'h28
`define OFS_RXHOLD 8'h30
`define OFS_TXHOLD 8'h34

// ----------------------------------------
// Control command bits
// ----------------------------------------
`define CTL_START 0
`define CTL_STOP 1
`define CTL_ENABLE 2
`define CTL_DISABLE 3
`define CTL_SWRESET 7

// ----------------------------------------
// Mode and clock wave fields
// ----------------------------------------
`define MODE_ADDR_LSB 0
`define MODE_READ 8
`define WAVE_LOW_LSB 0
`define WAVE_HIGH_LSB 8
`define WAVE_EXP_LSB 16

// ----------------------------------------
// Status bits, also the interrupt layout
// ----------------------------------------
`define ST_TRANSFER_COMPLETE_FLAG 0
`define ST_RECEIVE_READY_FLAG 1
`define ST_TRANSMIT_READY_FLAG 2
`define ST_ENABLED 4
`define ST_OVRE 6
`define ST_NACK 8
`define ST_LOCKOUT 9

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define RST_TRANSFER_COMPLETE_FLAG 1'b1
`define RST_TRANSMIT_READY_FLAG 1'b1
`define RST_DIV 8'h04
`define RST_EXP 3'h0
`define SCALED_MAX 13'h1fff

`endif

// *** bit_sync.v ***
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;

  // Lines idle high, so reset to ones
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_r <= {WIDTH{1'b1}};
      stage2_r <= {WIDTH{1'b1}};
    end else begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end

  assign dout = stage2_r;
endmodule
`default_nettype wire

// *** phase_timer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "i2c_defines.vh"
module phase_timer #(
  parameter DIV_W = 8,
  parameter EXP_W = 3,
  parameter CNT_W = 13
) (
  input wire clk,
  input wire reset_n,
  input wire [DIV_W-1:0] lowDiv,
  input wire [DIV_W-1:0] highDiv,
  input wire [EXP_W-1:0] prescaleExp,
  input wire selHigh,
  input wire restart,
  input wire run,
  output wire done
);
  reg [CNT_W-1:0] cnt_r;
  wire [CNT_W-1:0] target;

  // Products above the limit wrap; keeping below it is software's job
  function [CNT_W-1:0] scaled;
    input [DIV_W-1:0] div;
    input [EXP_W-1:0] ex;
    reg [CNT_W-1:0] wide;
    begin
      wide = {{(CNT_W-DIV_W){1'b0}}, div} << ex;
      scaled = (wide == {CNT_W{1'b0}}) ? {{(CNT_W-1){1'b0}}, 1'b1} : wide;
    end
  endfunction

  assign target = selHigh ? scaled(highDiv, prescaleExp) : scaled(lowDiv, prescaleExp);
  assign done = (cnt_r >= target);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= {CNT_W{1'b0}};
    end else if (restart) begin
      cnt_r <= {CNT_W{1'b0}};
    end else if (run && !done) begin
      cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// *** i2c_ctl_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "i2c_defines.vh"
module i2c_ctl_monitor (
  input wire clk,
  input wire reset_n,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire regRead,
  input wire [31:0] regRdata,
  input wire irq,
  input wire sclIn,
  input wire sclOut,
  input wire sclOeN,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOeN
);
  // ----
  // Shadow state snooped from the register port and the clock line
  // ----
  reg [7:0] lowR;
  reg [2:0] expR;
  reg maskOffR;
  reg statRdR;
  reg lockR;
  reg abortR;
  reg [15:0] lowCnt;
  wire statRd = regRead && regAddr == `OFS_STATUS;
  wire ctlWr = regWrite && regAddr == `OFS_CONTROL;
  wire [15:0] minLow = ({8'h00, lowR} << expR) | {15'h0000, lowR == 8'h00};
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lowR <= `RST_DIV;
      expR <= `RST_EXP;
      maskOffR <= 1'b1;
      statRdR <= 1'b0;
      lockR <= 1'b0;
      abortR <= 1'b0;
      lowCnt <= 16'h0000;
    end else begin
      if (regWrite && regAddr == `OFS_CLKWAVE) begin
        lowR <= regWdata[7:0];
        expR <= regWdata[18:16];
      end
      if (regWrite && regAddr == `OFS_INTMASK)
        maskOffR <= ~|{regWdata[8], regWdata[2:0]};
      statRdR <= statRd;
      lockR <= lockR | (statRdR & regRdata[`ST_LOCKOUT]);
      // A software reset cuts the low phase short, so that phase is not judged
      abortR <= (ctlWr & regWdata[`CTL_SWRESET]) | (abortR & ~sclOeN);
      lowCnt <= sclOeN ? 16'h0000 : lowCnt + 16'h0001;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence statRead;
    statRd;
  endsequence
  sequence disWrite;
    ctlWr && regWdata[`CTL_DISABLE];
  endsequence
  AST_RDATA_IDLE: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_OPEN_DRAIN: assert property (!sclOut && !sdaOut)
    else $error("line output level not zero");
  AST_NACK_TRANSFER_COMPLETE_FLAG: assert property (statRead ##1 regRdata[`ST_NACK] |-> regRdata[`ST_TRANSFER_COMPLETE_FLAG])
    else $error("not-ack seen without transfer complete");
  AST_NACK_CLEAR: assert property (statRead ##1 statRead |=> !regRdata[`ST_NACK])
    else $error("not-ack survived a status read");
  AST_DIS_FREEZE: assert property (disWrite |-> ##2 ($stable(sclOeN) && $stable(sdaOeN)) [*7])
    else $error("lines moved after disable");
  AST_LOCK_QUIET: assert property (lockR |-> sclOeN && sdaOeN)
    else $error("bus driven while locked out");
  AST_SCL_LOW_MIN: assert property ($rose(sclOeN) && !abortR |-> lowCnt >= minLow)
    else $error("clock low phase too short");
  AST_IRQ_MASKED: assert property (maskOffR |-> !irq)
    else $error("interrupt with all sources masked");
endmodule
bind i2c_master_controller i2c_ctl_monitor mon (.clk, .reset_n, .regAddr, .regWdata,
  .regWrite, .regRead, .regRdata, .irq, .sclIn, .sclOut, .sclOeN, .sdaIn, .sdaOut, .sdaOeN);
`default_nettype wire

// *** i2c_bus_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_slave (
  input wire logic scl,
  input wire logic sda,
  input wire logic nackAddr,
  input wire logic [7:0] rdByte,
  output logic sdaOeN,
  output logic [7:0] gotByte
);
  logic [7:0] sh;
  logic stop;
  logic done;
  logic rw;
  initial sdaOeN = 1'b1;
  // ----
  // Byte receive; data rising while the clock is high is a stop
  // ----
  task automatic rxByte();
    stop = 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge scl);
      sh = {sh[6:0], sda};
      @(negedge scl or posedge sda);
      if (scl) begin
        stop = 1'b1;
        return;
      end
    end
  endtask
  task automatic ackSlot(input logic give);
    sdaOeN = ~give;
    @(negedge scl);
    sdaOeN = 1'b1;
  endtask
  always begin
    @(negedge sda);
    if (scl === 1'b1) begin
      rxByte();
      rw = sh[0];
      if (!stop) begin
        ackSlot(!nackAddr);
        done = nackAddr;
        while (!done && !rw) begin
          rxByte();
          done = stop;
          if (!stop) begin
            gotByte = sh;
            ackSlot(1'b1);
          end
        end
        while (!done && rw) begin
          for (int i = 7; i >= 0; i--) begin
            sdaOeN = rdByte[i];
            @(negedge scl);
          end
          sdaOeN = 1'b1;
          @(posedge scl);
          done = sda;
          @(negedge scl);
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** test_i2c_master_controller.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "i2c_defines.vh"
module test_i2c_master_controller;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic nackAddr = 1'b0;
  logic [31:0] d, d2;
  wire [31:0] regRdata;
  wire irq, sclOut, sclOeN, sdaOut, sdaOeN, slvOeN;
  wire [7:0] gotByte;
  wire sda = sdaOeN & slvOeN;
  int bad_count = 0;
  int total_checks = 0;
  int n;
  always #5 clk = ~clk;
  i2c_master_controller dut (.clk, .reset_n, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .irq, .sclIn(sclOeN), .sclOut, .sclOeN, .sdaIn(sda), .sdaOut, .sdaOeN);
  i2c_bus_slave slv (.scl(sclOeN), .sda, .nackAddr, .rdByte(8'h3c), .sdaOeN(slvOeN), .gotByte);
  // ----
  // Bus tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    d = regRdata;
  endtask
  task automatic rd2();
    regAddr <= `OFS_STATUS;
    regRead <= 1'b1;
    repeat (2) @(posedge clk);
    d = regRdata;
    regRead <= 1'b0;
    @(posedge clk);
    d2 = regRdata;
  endtask
  task automatic waitIrq();
    for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clk);
    chk(irq, 1);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_write();
    rd(`OFS_STATUS);
    chk(d, 32'h5);
    rd(8'h3c);
    chk(d, 32'h0);
    wr(`OFS_MODE, 32'h2a);
    wr(`OFS_CLKWAVE, 32'h10305);
    wr(`OFS_TXHOLD, 32'ha5);
    wr(`OFS_INTMASK, 32'h1);
    wr(`OFS_CONTROL, 32'h5);
    while (sclOeN !== 1'b0) @(posedge clk);
    n = 0;
    while (sclOeN === 1'b0) begin
      @(posedge clk);
      n++;
    end
    chk(n >= 10 && n <= 12, 1);
    waitIrq();
    chk(gotByte, 8'ha5);
    rd(`OFS_RXHOLD);
    chk(d, 32'ha5);
    rd(`OFS_STATUS);
    chk(d, 32'h15);
    wr(`OFS_INTMASK, 32'h0);
    chk(irq, 0);
    wr(`OFS_INTMASK, 32'h1);
    chk(irq, 1);
    wr(`OFS_INTSTAT, 32'h1);
    chk(irq, 0);
    wr(`OFS_INTMASK, 32'h0);
    wr(`OFS_CONTROL, 32'h8);
    rd(`OFS_STATUS);
    chk(d, 32'h5);
    wr(`OFS_CONTROL, 32'h4);
    wr(`OFS_INTMASK, 32'h1);
  endtask
  task automatic t_rdwr();
    wr(`OFS_MODE, 32'h12a);
    wr(`OFS_CONTROL, 32'h1);
    wr(`OFS_CONTROL, 32'h2);
    waitIrq();
    rd(`OFS_STATUS);
    chk(d[`ST_RECEIVE_READY_FLAG], 1);
    wr(`OFS_INTSTAT, 32'h1);
    wr(`OFS_MODE, 32'h2a);
    wr(`OFS_TXHOLD, 32'h5a);
    wr(`OFS_CONTROL, 32'h1);
    waitIrq();
    rd(`OFS_STATUS);
    chk(d & 32'h42, 32'h2);
    rd(`OFS_RXHOLD);
    chk(d, 32'h5a);
    wr(`OFS_INTSTAT, 32'h1);
  endtask
  task automatic t_nack();
    nackAddr <= 1'b1;
    wr(`OFS_CONTROL, 32'h1);
    waitIrq();
    rd2();
    chk(d & 32'h101, 32'h101);
    chk(d2[`ST_NACK], 0);
    wr(`OFS_INTSTAT, 32'h1);
    wr(`OFS_CONTROL, 32'h1);
    // Ninth clock pulse is the ack slot; its falling edge detects the missing ack
    repeat (9) @(posedge sclOeN);
    @(negedge sclOeN);
    @(posedge clk);
    rd(`OFS_STATUS);
    chk(d[`ST_NACK], 0);
    waitIrq();
    rd(`OFS_STATUS);
    chk(d & 32'h101, 32'h1);
    nackAddr <= 1'b0;
    wr(`OFS_INTSTAT, 32'h1);
  endtask
  task automatic t_dis();
    logic [1:0] held;
    wr(`OFS_TXHOLD, 32'h77);
    wr(`OFS_CONTROL, 32'h1);
    repeat (60) @(posedge clk);
    wr(`OFS_CONTROL, 32'h8);
    held = {sclOeN, sdaOeN};
    rd(`OFS_STATUS);
    chk(d & 32'h5, 32'h0);
    repeat (100) @(posedge clk);
    chk({sclOeN, sdaOeN}, held);
    wr(`OFS_CONTROL, 32'h4);
    waitIrq();
    chk(gotByte, 8'h77);
    wr(`OFS_INTSTAT, 32'h1);
  endtask
  task automatic t_lock();
    wr(`OFS_CONTROL, 32'h1);
    while (sclOeN !== 1'b0) @(posedge clk);
    wr(`OFS_CONTROL, 32'h80);
    rd(`OFS_STATUS);
    chk(d[`ST_LOCKOUT], 1);
    wr(`OFS_CONTROL, 32'h5);
    n = 0;
    repeat (200) begin
      @(posedge clk);
      n += (sdaOeN !== 1'b1);
    end
    chk(n, 0);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_write();
    t_rdwr();
    t_nack();
    t_dis();
    t_lock();
    wrap_up();
  end
  initial begin
    #300000;
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
